// ---- rtl/kbd_matrix_encoder.sv ----
// keyboard matrix encoder: scans an 8 x 11 switch matrix, emits 9-bit code and strobe
// assumes sense inputs synchronous to clock; debounce length set by a port
`include "kbd_enc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module kbd_matrix_encoder (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic shift_level,
    input wire logic control_level,
    input wire logic [`KE_SENSE_STAGES-1:0] sense_return_lines,
    input wire kbd_enc_pkg::polarity_t polarity,
    input wire logic [15:0] debounce_cycles,
    output logic [`KE_DRIVE_STAGES-1:0] scan_drive_lines,
    output logic [8:0] key_code_outputs,
    output logic strobe,
    output logic scan_halted
);
    typedef enum logic [1:0] {st_scan, st_settle, st_debounce, st_hold} scan_state_t;

    scan_state_t state_q;
    logic [`KE_DRIVE_STAGES-1:0] drive_q;
    logic [`KE_SENSE_STAGES-1:0] sense_q;
    logic [15:0] delay_q;
    logic match;
    logic strobe_q;
    kbd_enc_pkg::bank_t bank;
    kbd_enc_pkg::key_word_t word_q;
    logic [6:0] word_index;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [3:0] onehot_index(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // one step of the drive ring, shared by the ring and the scan line register
    function automatic logic [`KE_DRIVE_STAGES-1:0] drive_step(input logic [`KE_DRIVE_STAGES-1:0] v);
        return {v[`KE_DRIVE_STAGES-2:0], v[`KE_DRIVE_STAGES-1]};
    endfunction

    // --------------------------------------------------------------
    // addressing
    // --------------------------------------------------------------
    // joint ring address
    always_comb begin
        word_index = 7'(onehot_index(16'(drive_q))) * 7'h0B + 7'(onehot_index(16'(sense_q)));
        if (control_level) begin
            bank = kbd_enc_pkg::bank_control;
        end else if (shift_level) begin
            bank = kbd_enc_pkg::bank_shift;
        end else begin
            bank = kbd_enc_pkg::bank_plain;
        end
    end

    kbd_code_store u_store (
        .clock(clock),
        .bank(bank),
        .word_index(word_index),
        .odd_parity(polarity.odd_parity),
        .word_q(word_q)
    );

    assign match = |(sense_return_lines & sense_q);

    // --------------------------------------------------------------
    // scan control
    // --------------------------------------------------------------
    // match halts clocks now
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= st_scan;
            delay_q <= 16'h0000;
        end else begin
            case (state_q)
                st_scan: begin
                    if (match) begin
                        state_q <= st_settle;
                    end
                end
                st_settle: begin
                    delay_q <= 16'h0000;
                    state_q <= match ? st_debounce : st_scan;
                end
                st_debounce: begin
                    if (!match) begin
                        state_q <= st_scan;
                    end else if (delay_q >= debounce_cycles) begin
                        state_q <= st_hold;
                    end else begin
                        delay_q <= delay_q + 16'h0001;
                    end
                end
                st_hold: begin
                    if (!match) begin
                        state_q <= st_scan;
                    end
                end
                default: state_q <= st_scan;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            drive_q <= `KE_DRIVE_RESET;
            sense_q <= `KE_SENSE_RESET;
        end else if (state_q == st_scan && !match) begin
            sense_q <= {sense_q[`KE_SENSE_STAGES-2:0], sense_q[`KE_SENSE_STAGES-1]};
            if (sense_q[`KE_SENSE_STAGES-1]) begin
                drive_q <= drive_step(drive_q);
            end
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    // drive the scan lines
    // steps with the drive ring: a copy one cycle late would pair sense stage 0 with the previous column
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            scan_drive_lines <= `KE_DRIVE_RESET;
            scan_halted <= 1'b0;
        end else begin
            if (state_q == st_scan && !match && sense_q[`KE_SENSE_STAGES-1]) begin
                scan_drive_lines <= drive_step(scan_drive_lines);
            end
            scan_halted <= (state_q != st_scan) || match;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            key_code_outputs <= 9'h000;
            strobe_q <= 1'b0;
            strobe <= 1'b0;
        end else begin
            strobe_q <= (state_q == st_hold) && match;
            strobe <= ((state_q == st_hold) && match) ^ polarity.data_strobe_invert;
            if (state_q != st_hold) begin
                key_code_outputs[`KE_PARITY_POS] <= word_q.parity ^ polarity.parity_invert;
                key_code_outputs[`KE_CODE_BITS-1:0] <= word_q.data ^ {`KE_CODE_BITS{polarity.data_strobe_invert}};
            end
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    sequence s_held;
        state_q == st_hold && match;
    endsequence

    property p_idle_scan;
        @(posedge clock) disable iff (!reset_n)
            (state_q == st_scan && !match) |=> (sense_q != $past(sense_q));
    endproperty
    a_idle_scan: assert property (p_idle_scan) else $error("rings not stepping while idle");

    property p_stop;
        @(posedge clock) disable iff (!reset_n)
            (state_q != st_scan || match) |=> $stable(drive_q) && $stable(sense_q);
    endproperty
    a_stop: assert property (p_stop) else $error("rings moved while halted");

    property p_strobe_after_hold;
        @(posedge clock) disable iff (!reset_n)
            s_held |=> (strobe_q == 1'b1);
    endproperty
    a_strobe_after_hold: assert property (p_strobe_after_hold) else $error("strobe missing on held key");

    property p_no_strobe_idle;
        @(posedge clock) disable iff (!reset_n)
            (state_q == st_scan) |=> !strobe_q;
    endproperty
    a_no_strobe_idle: assert property (p_no_strobe_idle) else $error("strobe while scanning");

    property p_code_hold;
        @(posedge clock) disable iff (!reset_n)
            (state_q == st_hold && $past(state_q) == st_hold) |=> $stable(key_code_outputs);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("code changed while held");

    property p_strobe_pol;
        @(posedge clock) disable iff (!reset_n)
            ##1 (strobe == (strobe_q ^ $past(polarity.data_strobe_invert)));
    endproperty
    a_strobe_pol: assert property (p_strobe_pol) else $error("strobe polarity wrong");

    property p_debounce;
        @(posedge clock) disable iff (!reset_n)
            (state_q == st_debounce && match && delay_q < debounce_cycles) |=> state_q != st_hold;
    endproperty
    a_debounce: assert property (p_debounce) else $error("strobe before debounce end");

    property p_release;
        @(posedge clock) disable iff (!reset_n)
            (state_q == st_hold && !match) |=> state_q == st_scan ##1 !strobe_q;
    endproperty
    a_release: assert property (p_release) else $error("release did not resume scan");

    property p_lockout;
        @(posedge clock) disable iff (!reset_n)
            s_held |=> $stable(drive_q);
    endproperty
    a_lockout: assert property (p_lockout) else $error("scan moved during lockout");

    property p_scan_lines;
        @(posedge clock) disable iff (!reset_n)
            scan_drive_lines == drive_q;
    endproperty
    a_scan_lines: assert property (p_scan_lines) else $error("scan lines differ from drive ring");
endmodule

`default_nettype wire

// ---- rtl/kbd_enc_consts.svh ----
// constants for the keyboard matrix encoder
// assumes inclusion by the encoder package and modules only
`ifndef KBD_ENC_CONSTS_SVH
`define KBD_ENC_CONSTS_SVH

`define KE_DRIVE_STAGES 8
`define KE_SENSE_STAGES 11
`define KE_BANK_WORDS 88
`define KE_STORE_WORDS 264
`define KE_CODE_BITS 8
`define KE_DRIVE_RESET 8'h01
`define KE_SENSE_RESET 11'h001
`define KE_PARITY_POS 8
`define KE_DEBOUNCE_DEF 16'h0100

`endif

// ---- rtl/kbd_enc_pkg.sv ----
// types for the keyboard matrix encoder
// assumes the constants header is on the include path
`include "kbd_enc_consts.svh"

package kbd_enc_pkg;
    typedef enum logic [1:0] {
        bank_plain,
        bank_shift,
        bank_control
    } bank_t;

    typedef struct packed {
        logic parity;
        logic [`KE_CODE_BITS-1:0] data;
    } key_word_t;

    typedef struct packed {
        logic parity_invert;
        logic data_strobe_invert;
        logic odd_parity;
    } polarity_t;
endpackage

// ---- rtl/kbd_code_store.sv ----
// mask-programmed code store: three banks of 88 eight-bit codes plus parity
// assumes a synchronous read one cycle after the address is presented
`include "kbd_enc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module kbd_code_store (
    input wire logic clock,
    input wire kbd_enc_pkg::bank_t bank,
    input wire logic [6:0] word_index,
    input wire logic odd_parity,
    output kbd_enc_pkg::key_word_t word_q
);
    logic [`KE_CODE_BITS-1:0] store_mem [0:`KE_STORE_WORDS-1];
    logic [8:0] address;
    logic [`KE_CODE_BITS-1:0] code;

    // --------------------------------------------------------------
    // pattern standing in for the mask contents
    // --------------------------------------------------------------
    initial begin
        for (int i = 0; i < `KE_STORE_WORDS; i++) begin
            store_mem[i] = 8'(i);
        end
    end

    always_comb begin
        address = 9'(word_index) + 9'(bank) * 9'(`KE_BANK_WORDS);
        code = store_mem[address];
    end

    always_ff @(posedge clock) begin
        word_q.data <= code;
        word_q.parity <= (^code) ^ odd_parity;
    end
endmodule

`default_nettype wire

// ---- dv/kbd_matrix_model.sv ----
// switch matrix model: up to two closed keys at scan and sense crossings
// assumes a one-hot scan drive from the encoder
`timescale 1ns/1ns
`default_nettype none

module kbd_matrix_model (
    input wire logic [7:0] scan_drive_lines,
    input wire logic [1:0] key_down,
    input wire logic [2:0] drive_a,
    input wire logic [3:0] sense_a,
    input wire logic [2:0] drive_b,
    input wire logic [3:0] sense_b,
    output logic [10:0] sense_return_lines
);
    // one switch per crossing
    // open sense lines fall to the pull-down level
    always_comb begin
        sense_return_lines = 11'h000;
        if (key_down[0] && scan_drive_lines[drive_a]) begin
            sense_return_lines[sense_a] = 1'b1;
        end
        if (key_down[1] && scan_drive_lines[drive_b]) begin
            sense_return_lines[sense_b] = 1'b1;
        end
    end
endmodule

`default_nettype wire

// ---- dv/keyboard_matrix_encoder_test.sv ----
// testbench for the keyboard matrix encoder
// assumes the encoder, its package and the matrix model are compiled first
`timescale 1ns/1ns
`default_nettype none

module keyboard_matrix_encoder_test;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic shift_level = 1'b0;
    logic control_level = 1'b0;
    kbd_enc_pkg::polarity_t polarity = '0;
    logic [15:0] debounce_cycles = 16'h0002;
    logic [1:0] key_down = 2'h0;
    logic [2:0] drive_a = 3'h0;
    logic [2:0] drive_b = 3'h0;
    logic [3:0] sense_a = 4'h0;
    logic [3:0] sense_b = 4'h0;
    logic [10:0] sense_return_lines;
    logic [7:0] scan_drive_lines;
    logic [8:0] key_code_outputs;
    logic strobe;
    logic scan_halted;
    logic valid_q = 1'b0;
    logic held = 1'b0;
    logic [8:0] notes[$];
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'hA9BF;
    int halt_cycles = 0;

    always #50 clock = ~clock;

    kbd_matrix_encoder dut (.clock(clock), .reset_n(reset_n), .shift_level(shift_level),
        .control_level(control_level), .sense_return_lines(sense_return_lines), .polarity(polarity),
        .debounce_cycles(debounce_cycles), .scan_drive_lines(scan_drive_lines),
        .key_code_outputs(key_code_outputs), .strobe(strobe), .scan_halted(scan_halted));

    kbd_matrix_model partner (.scan_drive_lines(scan_drive_lines), .key_down(key_down), .drive_a(drive_a),
        .sense_a(sense_a), .drive_b(drive_b), .sense_b(sense_b), .sense_return_lines(sense_return_lines));

    task check(input logic [8:0] seen, input logic [8:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    function logic [8:0] expect_code(input logic [2:0] d, input logic [3:0] s);
        logic [8:0] w;
        w = (control_level ? 9'h0B0 : shift_level ? 9'h058 : 9'h000) + d * 9'h00B + s;
        return {^w[7:0] ^ polarity.odd_parity ^ polarity.parity_invert, w[7:0] ^ {8{polarity.data_strobe_invert}}};
    endfunction

    task wait_lvl(input logic lvl);
        int n;
        n = 0;
        while (((strobe ^ polarity.data_strobe_invert) !== lvl) && n < 2000) begin
            @(negedge clock);
            n++;
        end
        if (n >= 2000) begin
            errors++;
        end
    endtask

    task close_out;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // monitor: takes the oldest note on each new strobe
    // ----------------------------------------
    always @(posedge clock) begin
        halt_cycles = scan_halted ? halt_cycles + 1 : 0;
        valid_q <= strobe ^ polarity.data_strobe_invert;
        if (held && !valid_q && (strobe ^ polarity.data_strobe_invert)) begin
            if (notes.size() == 0) begin
                check(key_code_outputs, ~key_code_outputs);
            end else begin
                check(key_code_outputs, notes.pop_front());
            end
            check({8'h00, halt_cycles >= debounce_cycles}, 9'h001);
        end
    end

    // ----------------------------------------
    // driver
    // ----------------------------------------
    task encode(input logic roll);
        @(negedge clock);
        {control_level, shift_level} = 2'($random(seed));
        polarity = 3'($random(seed));
        debounce_cycles = 16'h0002 + 16'($random(seed) & 3);
        drive_a = 3'($random(seed));
        sense_a = 4'($unsigned($random(seed)) % 11);
        drive_b = drive_a + 3'h3;
        sense_b = 4'((sense_a + 1) % 11);
        repeat (4) @(negedge clock);
        notes.push_back(expect_code(drive_a, sense_a));
        held = 1'b1;
        key_down = 2'h1;
        wait_lvl(1'b1);
        check({1'b0, scan_drive_lines}, 9'h001 << drive_a);
        key_down = {roll, 1'b1};
        repeat (roll ? 200 : 5) @(negedge clock);
        check(key_code_outputs, expect_code(drive_a, sense_a));
        if (roll) begin
            notes.push_back(expect_code(drive_b, sense_b));
            key_down = 2'h2;
            wait_lvl(1'b0);
            wait_lvl(1'b1);
        end
        key_down = 2'h0;
        repeat (3) @(negedge clock);
        check({8'h00, strobe ^ polarity.data_strobe_invert}, 9'h000);
        held = 1'b0;
    endtask

    initial begin
        repeat (16) @(negedge clock);
        reset_n = 1'b1;
        repeat (16) begin
            encode(1'b0);
        end
        encode(1'b1);
        encode(1'b1);
        // short closure released in the settle cycle, before the debounce wait starts
        held = 1'b1;
        key_down = 2'h1;
        repeat (200) begin
            if (!scan_halted) @(negedge clock);
        end
        check({8'h00, scan_halted}, 9'h001);
        key_down = 2'h0;
        repeat (20) @(negedge clock);
        check({8'h00, scan_halted}, 9'h000);
        held = 1'b0;
        close_out();
    end

    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        close_out();
    end
endmodule

`default_nettype wire
